//--- core/charge_ctl_pkg.sv
// Constants and types shared by the charge control state machine.
package charge_ctl_pkg;
  localparam int unsigned clk_mhz = 125;
  // Current command in percent of the programmed fast-charge current.
  localparam logic [6:0] pct_off = 7'h00;
  localparam logic [6:0] pct_precharge = 7'h14;
  localparam logic [6:0] pct_step1 = 7'h14;
  localparam logic [6:0] pct_step2 = 7'h3C;
  localparam logic [6:0] pct_full = 7'h64;
  localparam logic [6:0] pct_terminate = 7'h0A;
  // Timing figures in microseconds, as printed.
  localparam int unsigned term_window_min_us = 300;
  localparam int unsigned term_window_max_us = 550;
  localparam int unsigned full_status_us = 750;
  localparam int unsigned supply_filter_us = 100;
  localparam int unsigned soft_step_us = 100;
  // Derived cycle counts; whole microseconds times whole megahertz, so no count is rounded.
  localparam int unsigned term_window_min_cyc = term_window_min_us * clk_mhz;
  localparam int unsigned term_window_max_cyc = term_window_max_us * clk_mhz;
  localparam int unsigned full_status_cyc = full_status_us * clk_mhz;
  localparam int unsigned supply_filter_cyc = supply_filter_us * clk_mhz;
  localparam int unsigned soft_step_cyc = soft_step_us * clk_mhz;
  // Tri-level enable/mode input, coded by two comparator bits.
  typedef enum logic [1:0] {
    mode_float = 2'h0,
    mode_monitor = 2'h1,
    mode_disabled = 2'h2
  } enable_mode_t;
  typedef enum {
    st_idle,
    st_precharge,
    st_cc_step1,
    st_cc_step2,
    st_cc_full,
    st_cv,
    st_float,
    st_monitor
  } charge_state_t;
endpackage

//--- core/liion_charge_control_fsm.sv
// Control state machine of a single-cell lithium-ion linear charger.
//
// Functional notes
// - New supply starts cycle, asserts status low.
// - Below pre-charge threshold: 20% current.
// - Pre-charge threshold 2.9V, entered automatically.
// - Fast-charge soft-starts 20%, 60%, 100%.
// - Constant current only between thresholds.
// - At 4.2V switch to voltage regulation.
// - Current under 10% terminates, releases status.
// - Termination counts peak load over window.
// - Mode selects float-charge or monitor after termination.
// - Monitor until 100mV drop, then recharge.
// - Recharge cycles leave status output released.
// - Host may force a recharge cycle.
// - Glitch filter on supply valid indication.
// - Enable input: low float, mid monitor, high off.
// - Leaving disabled range starts cycle, asserts status.
// - Already full at start: status 750us pulse.
`timescale 1ns/10ps
module liion_charge_control_fsm #(
  parameter int unsigned term_window_cycles = charge_ctl_pkg::term_window_min_cyc,
  parameter int unsigned full_status_cycles = charge_ctl_pkg::full_status_cyc,
  parameter int unsigned supply_filter_cycles = charge_ctl_pkg::supply_filter_cyc,
  parameter int unsigned soft_step_cycles = charge_ctl_pkg::soft_step_cyc
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic supply_valid,
  input wire logic above_precharge,
  input wire logic at_full_charge,
  input wire logic below_recharge,
  input wire logic battery_below_term,
  input wire logic load_below_term,
  input wire logic [1:0] enable_mode_select,
  output logic [6:0] current_command_pct,
  output logic voltage_regulation,
  output logic output_enable,
  output logic charge_status_n_oe,
  output logic charge_status_n_out,
  output logic [2:0] charge_state
);

  localparam int unsigned nflags = 8;
  // Idle value of the flags: every comparator low and the mode code in the
  // disabled range, so that no false mode edge follows reset.
  localparam logic [nflags-1:0] flag_idle = 8'h80;

  // Three-stage synchronisers; a change counts once stages two and three agree.
  // Agreement is checked per bit, so a two-bit mode code may pass through a
  // neighbouring code for one clock while it changes; idle ignores such a blip.
  logic [nflags-1:0] raw;
  logic [nflags-1:0] sync1_reg;
  logic [nflags-1:0] sync2_reg;
  logic [nflags-1:0] sync3_reg;
  logic [nflags-1:0] flag_reg;

  assign raw = {enable_mode_select, load_below_term, battery_below_term, below_recharge,
                at_full_charge, above_precharge, supply_valid};

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= flag_idle;
      sync2_reg <= flag_idle;
      sync3_reg <= flag_idle;
      flag_reg <= flag_idle;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < nflags; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          flag_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // Synchronised comparator flags, named for what the state machine asks of them.
  logic supply_raw;
  logic pre_ok;
  logic full_v;
  logic recharge_drop;
  logic bat_low_i;
  logic load_low_i;
  logic [1:0] mode_bits;
  assign supply_raw = flag_reg[0];
  assign pre_ok = flag_reg[1];
  assign full_v = flag_reg[2];
  assign recharge_drop = flag_reg[3];
  assign bat_low_i = flag_reg[4];
  assign load_low_i = flag_reg[5];
  assign mode_bits = flag_reg[7:6];

  // Decoded mode; the unused code reads as disabled so a fault never charges.
  logic mode_float_sel;
  logic mode_monitor_sel;
  logic mode_off;
  assign mode_float_sel = mode_bits == charge_ctl_pkg::mode_float;
  assign mode_monitor_sel = mode_bits == charge_ctl_pkg::mode_monitor;
  assign mode_off = !(mode_float_sel || mode_monitor_sel);

  // Supply must stay valid for the whole filter time before it is accepted.
  // Any dropout restarts the count, so a supply ringing across the lockout
  // threshold is accepted only after it has been quiet for the whole time.
  logic [$clog2(supply_filter_cycles+1)-1:0] filt_cnt_reg;
  logic supply_ok_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      filt_cnt_reg <= '0;
      supply_ok_reg <= 1'b0;
    end else if (!supply_raw) begin
      filt_cnt_reg <= '0;
      supply_ok_reg <= 1'b0;
    end else if (filt_cnt_reg == ($clog2(supply_filter_cycles+1))'(supply_filter_cycles)) begin
      supply_ok_reg <= 1'b1;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 1'b1;
    end
  end

  // The load-below flag must hold high for the full look-back window, so the peak
  // load over that window stays below the termination threshold.
  // The short end of the window is used: termination comes sooner, at the
  // cost of forgetting a load burst sooner.
  logic [$clog2(term_window_cycles+1)-1:0] load_cnt_reg;
  logic load_quiet;
  always_ff @(posedge clk) begin
    if (reset || !load_low_i) begin
      load_cnt_reg <= '0;
    end else if (!load_quiet) begin
      load_cnt_reg <= load_cnt_reg + 1'b1;
    end
  end
  assign load_quiet = load_cnt_reg == ($clog2(term_window_cycles+1))'(term_window_cycles);

  logic terminate;
  assign terminate = bat_low_i && load_quiet;

  // Edge detect of session start: supply acceptance or leaving disabled range.
  // Edges, not levels, so a recharge or a return from float is never a new session.
  logic enabled;
  logic enabled_d_reg;
  logic float_d_reg;
  assign enabled = supply_ok_reg && !mode_off;
  always_ff @(posedge clk) begin
    if (reset) begin
      enabled_d_reg <= 1'b0;
      float_d_reg <= 1'b0;
    end else begin
      enabled_d_reg <= enabled;
      float_d_reg <= mode_float_sel;
    end
  end
  logic start_cycle;
  assign start_cycle = enabled && !enabled_d_reg;

  // Only the edge into the low range is seen; holding it long enough for the
  // recharge to take is left to the host.
  logic force_req;
  assign force_req = mode_float_sel && !float_d_reg;

  charge_ctl_pkg::charge_state_t state_reg;
  charge_ctl_pkg::charge_state_t state_next;
  logic [$clog2(soft_step_cycles+1)-1:0] step_cnt_reg;
  logic step_done;
  assign step_done = step_cnt_reg == ($clog2(soft_step_cycles+1))'(soft_step_cycles);

  // Supply loss or the disabled range overrides every transition below, so no
  // charging state outlives the session that started it.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      charge_ctl_pkg::st_idle: begin
        if (start_cycle) begin
          if (!pre_ok) state_next = charge_ctl_pkg::st_precharge;
          else if (full_v) state_next = charge_ctl_pkg::st_cv;
          else state_next = charge_ctl_pkg::st_cc_step1;
        end
      end
      charge_ctl_pkg::st_precharge: begin
        if (pre_ok) state_next = charge_ctl_pkg::st_cc_step1;
      end
      charge_ctl_pkg::st_cc_step1: begin
        // A battery sagging below the pre-charge threshold falls back to 20%.
        if (!pre_ok) state_next = charge_ctl_pkg::st_precharge;
        else if (full_v) state_next = charge_ctl_pkg::st_cv;
        else if (step_done) state_next = charge_ctl_pkg::st_cc_step2;
      end
      charge_ctl_pkg::st_cc_step2: begin
        if (!pre_ok) state_next = charge_ctl_pkg::st_precharge;
        else if (full_v) state_next = charge_ctl_pkg::st_cv;
        else if (step_done) state_next = charge_ctl_pkg::st_cc_full;
      end
      charge_ctl_pkg::st_cc_full: begin
        if (!pre_ok) state_next = charge_ctl_pkg::st_precharge;
        else if (full_v) state_next = charge_ctl_pkg::st_cv;
      end
      charge_ctl_pkg::st_cv: begin
        if (terminate) begin
          if (mode_float_sel) state_next = charge_ctl_pkg::st_float;
          else state_next = charge_ctl_pkg::st_monitor;
        end
      end
      charge_ctl_pkg::st_float: begin
        // Moving to mid range lets a forced recharge terminate again.
        if (mode_monitor_sel) state_next = charge_ctl_pkg::st_cv;
      end
      charge_ctl_pkg::st_monitor: begin
        // A sag to the recharge level wins over a forced recharge, since the full
        // soft-started sequence is the gentler way back to charging.
        if (recharge_drop) state_next = charge_ctl_pkg::st_cc_step1;
        else if (force_req) state_next = charge_ctl_pkg::st_cv;
      end
      default: state_next = charge_ctl_pkg::st_idle;
    endcase
    if (!enabled) state_next = charge_ctl_pkg::st_idle;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= charge_ctl_pkg::st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  // Restarts on every state change, so each soft-start step lasts
  // soft_step_cycles + 1 clocks.
  always_ff @(posedge clk) begin
    if (reset || state_next != state_reg) begin
      step_cnt_reg <= '0;
    end else if (!step_done) begin
      step_cnt_reg <= step_cnt_reg + 1'b1;
    end
  end

  // Status output: asserted only for cycles started by supply or enable.
  // Recharges never set it, so it stays released across them.
  logic status_reg;
  logic [$clog2(full_status_cycles+1)-1:0] full_cnt_reg;
  logic full_pulse_reg;
  always_ff @(posedge clk) begin
    if (reset || !enabled) begin
      status_reg <= 1'b0;
      full_pulse_reg <= 1'b0;
      full_cnt_reg <= '0;
    end else if (start_cycle) begin
      status_reg <= 1'b1;
      full_pulse_reg <= pre_ok && full_v;
      full_cnt_reg <= '0;
    end else if (state_reg == charge_ctl_pkg::st_cv && terminate) begin
      // Termination wins over the already-full pulse, so a session that ends
      // during the pulse still leaves the pin released.
      status_reg <= 1'b0;
      full_pulse_reg <= 1'b0;
    end else if (full_pulse_reg) begin
      if (full_cnt_reg == ($clog2(full_status_cycles+1))'(full_status_cycles)) begin
        status_reg <= 1'b0;
        full_pulse_reg <= 1'b0;
      end else begin
        full_cnt_reg <= full_cnt_reg + 1'b1;
      end
    end
  end

  // Outputs registered from next state so they track the state without lag.
  // This keeps every output of this block a flip-flop while matching charge_state exactly.
  always_ff @(posedge clk) begin
    if (reset) begin
      current_command_pct <= charge_ctl_pkg::pct_off;
      voltage_regulation <= 1'b0;
      output_enable <= 1'b0;
      charge_state <= 3'h0;
    end else begin
      charge_state <= 3'(state_next);
      voltage_regulation <= state_next == charge_ctl_pkg::st_cv ||
                            state_next == charge_ctl_pkg::st_float;
      output_enable <= !(state_next == charge_ctl_pkg::st_idle ||
                         state_next == charge_ctl_pkg::st_monitor);
      case (state_next)
        charge_ctl_pkg::st_precharge: current_command_pct <= charge_ctl_pkg::pct_precharge;
        charge_ctl_pkg::st_cc_step1: current_command_pct <= charge_ctl_pkg::pct_step1;
        charge_ctl_pkg::st_cc_step2: current_command_pct <= charge_ctl_pkg::pct_step2;
        charge_ctl_pkg::st_cc_full: current_command_pct <= charge_ctl_pkg::pct_full;
        // In voltage regulation the full value is only a ceiling; the voltage loop
        // sets the current actually drawn.
        charge_ctl_pkg::st_cv: current_command_pct <= charge_ctl_pkg::pct_full;
        charge_ctl_pkg::st_float: current_command_pct <= charge_ctl_pkg::pct_full;
        default: current_command_pct <= charge_ctl_pkg::pct_off;
      endcase
    end
  end

  // Open drain: the pin is only ever pulled low.
  // The enable is high while the pin is pulled, which asserts the status.
  assign charge_status_n_out = 1'b0;
  assign charge_status_n_oe = status_reg;

endmodule // liion_charge_control_fsm

//--- dv/charge_env_model.sv
// Adapter and battery model: comparator flags from a coarse battery level.
`timescale 1ns/10ps
module charge_env_model (
  input wire logic supply_on,
  input wire logic [1:0] level,
  input wire logic term_ok,
  input wire logic voltage_regulation,
  output logic supply_valid,
  output logic above_precharge,
  output logic at_full_charge,
  output logic below_recharge,
  output logic battery_below_term,
  output logic load_below_term
);
  // Level 0 deep discharge, 1 mid, 2 full, 3 sagged by the recharge margin.
  assign supply_valid = supply_on;
  assign above_precharge = level != 2'h0;
  assign at_full_charge = level == 2'h2;
  assign below_recharge = level == 2'h3;
  // Battery current only tapers while the voltage is being regulated.
  assign battery_below_term = term_ok & voltage_regulation;
  assign load_below_term = term_ok;
endmodule // charge_env_model

//--- dv/liion_charge_control_fsm_bench.sv
// Self-checking bench for the charge control state machine.
`timescale 1ns/10ps
module liion_charge_control_fsm_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic supply_on = 1'b0;
  logic [1:0] level = 2'h0;
  logic term_ok = 1'b0;
  logic [1:0] enable_mode_select = 2'h2;
  logic supply_valid, above_precharge, at_full_charge, below_recharge;
  logic battery_below_term, load_below_term, voltage_regulation, output_enable;
  logic charge_status_n_oe, charge_status_n_out;
  logic [6:0] current_command_pct;
  logic [2:0] charge_state;
  int errors = 0;
  int n_compared = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  charge_env_model env_u (.supply_on, .level, .term_ok, .voltage_regulation, .supply_valid,
    .above_precharge, .at_full_charge, .below_recharge, .battery_below_term, .load_below_term);
  liion_charge_control_fsm #(.term_window_cycles(20), .full_status_cycles(30),
    .supply_filter_cycles(10), .soft_step_cycles(5)) dut_u (.clk, .reset, .supply_valid,
    .above_precharge, .at_full_charge, .below_recharge, .battery_below_term,
    .load_below_term, .enable_mode_select, .current_command_pct, .voltage_regulation,
    .output_enable, .charge_status_n_oe, .charge_status_n_out, .charge_state);
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A percentage of 7'h7F means the command is not compared.
  task automatic expect_st(input logic [2:0] s, input logic [6:0] pct, input logic stat);
    for (int i = 0; i < 300 && charge_state !== s; i++) @(negedge clk);
    check({4'h0, charge_state}, {4'h0, s});
    if (pct != 7'h7F) check(current_command_pct, pct);
    check({6'h00, charge_status_n_oe}, {6'h00, stat});
  endtask
  initial begin
    #60000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    expect_st(3'h0, 7'h00, 1'b0);
    enable_mode_select = 2'h1;
    supply_on = 1'b1;
    repeat (4) @(negedge clk);
    supply_on = 1'b0;
    repeat (30) @(negedge clk);
    check({4'h0, charge_state}, 7'h00);
    supply_on = 1'b1;
    expect_st(3'h1, 7'h14, 1'b1);
    check({6'h00, charge_status_n_out}, 7'h00);
    level = 2'h1;
    expect_st(3'h2, 7'h14, 1'b1);
    expect_st(3'h3, 7'h3C, 1'b1);
    expect_st(3'h4, 7'h64, 1'b1);
    level = 2'h2;
    expect_st(3'h5, 7'h64, 1'b1);
    check({6'h00, voltage_regulation}, 7'h01);
    term_ok = 1'b1;
    repeat (10) @(negedge clk);
    check({4'h0, charge_state}, 7'h05);
    expect_st(3'h7, 7'h7F, 1'b0);
    check({6'h00, output_enable}, 7'h00);
    term_ok = 1'b0;
    level = 2'h3;
    expect_st(3'h2, 7'h14, 1'b0);
    level = 2'h2;
    expect_st(3'h5, 7'h64, 1'b0);
    term_ok = 1'b1;
    expect_st(3'h7, 7'h7F, 1'b0);
    term_ok = 1'b0;
    enable_mode_select = 2'h0;
    expect_st(3'h5, 7'h7F, 1'b0);
    repeat (150) @(negedge clk);
    term_ok = 1'b1;
    expect_st(3'h6, 7'h7F, 1'b0);
    check({6'h00, output_enable}, 7'h01);
    enable_mode_select = 2'h1;
    expect_st(3'h7, 7'h7F, 1'b0);
    enable_mode_select = 2'h3;
    expect_st(3'h0, 7'h00, 1'b0);
    term_ok = 1'b0;
    enable_mode_select = 2'h1;
    expect_st(3'h5, 7'h7F, 1'b1);
    repeat (20) @(negedge clk);
    check({6'h00, charge_status_n_oe}, 7'h01);
    repeat (20) @(negedge clk);
    check({6'h00, charge_status_n_oe}, 7'h00);
    supply_on = 1'b0;
    expect_st(3'h0, 7'h00, 1'b0);
    stop_test();
  end
endmodule // liion_charge_control_fsm_bench

//--- dv/liion_charge_control_fsm_props.sv
// Port assertions for the charge control state machine.
`timescale 1ns/10ps
module charge_ctl_checker #(
  parameter int unsigned term_window_cycles = 20,
  parameter int unsigned full_status_cycles = 30,
  parameter int unsigned supply_filter_cycles = 10,
  parameter int unsigned soft_step_cycles = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic supply_valid,
  input wire logic above_precharge,
  input wire logic at_full_charge,
  input wire logic below_recharge,
  input wire logic battery_below_term,
  input wire logic load_below_term,
  input wire logic [1:0] enable_mode_select,
  input wire logic [6:0] current_command_pct,
  input wire logic voltage_regulation,
  input wire logic output_enable,
  input wire logic charge_status_n_oe,
  input wire logic charge_status_n_out,
  input wire logic [2:0] charge_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  pre_pct_a: assert property (charge_state == 3'h1 |-> current_command_pct == 7'h14)
    else $error("Pre-charge current wrong.");
  cc_pct_a: assert property (charge_state == 3'h3 |-> current_command_pct == 7'h3C)
    else $error("Middle soft-start step wrong.");
  step_order_a: assert property ((charge_state == 3'h3 && $past(charge_state) != 3'h3)
    |-> $past(charge_state) == 3'h2)
    else $error("Soft-start steps out of order.");
  step_hold_a: assert property ((charge_state == 3'h4 && $past(charge_state) == 3'h3)
    |-> $past(charge_state, 5) == 3'h3)
    else $error("Soft-start step too short.");
  cv_reg_a: assert property (charge_state == 3'h5 |-> voltage_regulation && output_enable)
    else $error("Voltage regulation missing.");
  float_on_a: assert property (charge_state == 3'h6
    |-> voltage_regulation && output_enable && !charge_status_n_oe)
    else $error("Float-charge outputs wrong.");
  monitor_off_a: assert property (charge_state == 3'h7 |-> !output_enable && !charge_status_n_oe)
    else $error("Monitor state output not off.");
  quiet_a: assert property (charge_state == 3'h7 ##1 1'b1 |-> !charge_status_n_oe)
    else $error("Recharge asserted status.");
  idle_off_a: assert property (charge_state == 3'h0
    |-> !output_enable && current_command_pct == 7'h00 && !charge_status_n_oe)
    else $error("Idle outputs not off.");
  filter_a: assert property (($past(charge_state) == 3'h0 && charge_state != 3'h0)
    |-> $past(supply_valid, supply_filter_cycles))
    else $error("Cycle began on unfiltered supply.");
endmodule // charge_ctl_checker

bind liion_charge_control_fsm charge_ctl_checker #(
  .term_window_cycles(term_window_cycles),
  .full_status_cycles(full_status_cycles),
  .supply_filter_cycles(supply_filter_cycles),
  .soft_step_cycles(soft_step_cycles)
) chk_u (.clk, .reset, .supply_valid, .above_precharge, .at_full_charge, .below_recharge,
  .battery_below_term, .load_below_term, .enable_mode_select, .current_command_pct,
  .voltage_regulation, .output_enable, .charge_status_n_oe, .charge_status_n_out,
  .charge_state);
